//--- rtl/cpb_pkg.sv
// constants, modes and decode helpers for the configurable pad bank
package cpb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bank geometry
    localparam int NUM_PADS = 27;
    localparam int NUM_PRI  = 10;
    localparam int NUM_GRP  = 4;

    // pad positions of the two indicator functions
    localparam int PAD_NET_STATUS = 0;
    localparam int PAD_SW_READY   = 7;

    // peripheral groups owning the additional pads
    localparam logic [1:0] GRP_WIRELESS = 2'h0; // wireless reset and sdio, pads 10..16
    localparam logic [1:0] GRP_COEX     = 2'h1; // coexistence link, pads 17..18
    localparam logic [1:0] GRP_UART     = 2'h2; // modem lines, pads 19..22
    localparam logic [1:0] GRP_SPI      = 2'h3; // spi, pads 23..26
    localparam int FIRST_COEX = 17;
    localparam int FIRST_UART = 19;
    localparam int FIRST_SPI  = 23;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and masks
    localparam logic [26:0] WAKE_MASK    = 27'h0000099; // pads one, four, five, eight
    localparam logic [26:0] ALT_RST      = 27'h0000081; // indicator pads start as alt
    localparam logic [26:0] OUT_RST      = 27'h0000000;
    localparam logic [26:0] OE_N_RST     = 27'h7ffff7e; // indicator pads driven low
    localparam logic [26:0] STATUS_RST   = 27'h0000000;

    ////////////////////////////////////////////////////////////////////////////
    // pad roles
    typedef enum logic [1:0] {CPB_IN, CPB_OUT, CPB_ALT} cpb_mode_e;

    // two-bit mode code written by firmware: 0 input, 1 output, else alt
    function automatic cpb_mode_e cpb_decode(input logic [1:0] code);
        cpb_mode_e m;
        m = CPB_ALT;
        case (code)
            2'h0:    m = CPB_IN;
            2'h1:    m = CPB_OUT;
            default: m = CPB_ALT;
        endcase
        return m;
    endfunction

    // peripheral group of an additional pad
    function automatic logic [1:0] cpb_group(input int pad);
        logic [1:0] g;
        g = GRP_WIRELESS;
        if (pad >= FIRST_SPI)
            g = GRP_SPI;
        else if (pad >= FIRST_UART)
            g = GRP_UART;
        else if (pad >= FIRST_COEX)
            g = GRP_COEX;
        return g;
    endfunction

endpackage

//--- rtl/cpb_sync.sv
// two-stage synchroniser for asynchronous pad levels
`timescale 1ns/1ps
module cpb_sync #(
    parameter int WIDTH = 27
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

//--- rtl/cpb_pad_bank.sv
// configurable general-purpose pad bank with interrupt and wakeup flags
`timescale 1ns/1ps
module cpb_pad_bank (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // pads, three signals each
    input  wire logic [26:0] pad_in,
    output logic      [26:0] pad_out,
    output logic      [26:0] pad_oe_n,
    // role configuration, two bits per pad
    input  wire logic        mode_wr,
    input  wire logic [53:0] mode_wr_data,
    input  wire logic [3:0]  periph_unused,
    // software data access
    input  wire logic [26:0] out_wr_en,
    input  wire logic [26:0] out_wr_data,
    output logic      [26:0] out_value,
    output logic      [26:0] in_value,
    // internal alternative-function drivers
    input  wire logic [26:0] alt_out,
    input  wire logic [26:0] alt_oe,
    input  wire logic [9:0]  i2c_sel,
    input  wire logic [9:0]  i2c_pull_low,
    input  wire logic        network_status_indicator,
    input  wire logic        software_ready_indicator,
    // interrupt and wakeup flags
    input  wire logic [26:0] irq_enable,
    input  wire logic [26:0] irq_clear,
    input  wire logic [26:0] wake_enable,
    output logic      [26:0] irq_status,
    output logic             irq,
    output logic             wake
);

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    cpb_pkg::cpb_mode_e mode_r   [27];
    cpb_pkg::cpb_mode_e eff_mode [27];
    logic [26:0]        pin_sync;
    logic [26:0]        pin_prev_r;
    logic [26:0]        is_in_v;
    logic [26:0]        is_out_v;
    logic [26:0]        pad_out_nxt;
    logic [26:0]        pad_oe_n_nxt;
    logic [26:0]        set_v;
    logic [26:0]        irq_status_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // pad level capture
    cpb_sync #(
        .WIDTH    (27)
    ) u_sync (
        .clock    (clock),
        .reset    (reset),
        .async_in (pad_in),
        .sync_out (pin_sync)
    );

    // previous level for edge detection, and level readback
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pin_prev_r <= '0;
            in_value   <= '0;
        end
        else
        begin
            pin_prev_r <= pin_sync;
            in_value   <= pin_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pad role, output latch and drive
    genvar p;
    generate
        for (p = 0; p < 27; p++)
        begin : g_pad
            // role register, indicator pads start as alternative function
            always_ff @(posedge clock)
            begin
                if (reset)
                    mode_r[p] <= cpb_pkg::ALT_RST[p] ? cpb_pkg::CPB_ALT : cpb_pkg::CPB_IN;
                else if (mode_wr)
                    mode_r[p] <= cpb_pkg::cpb_decode(mode_wr_data[2*p +: 2]);
            end

            // output latch holds until rewritten
            always_ff @(posedge clock)
            begin
                if (reset)
                    out_value[p] <= cpb_pkg::OUT_RST[p];
                else if (out_wr_en[p])
                    out_value[p] <= out_wr_data[p];
            end

            // additional pads follow their peripheral while it is in use
            always_comb
            begin
                eff_mode[p] = mode_r[p];
                if (p >= cpb_pkg::NUM_PRI && !periph_unused[cpb_pkg::cpb_group(p)])
                    eff_mode[p] = cpb_pkg::CPB_ALT;
            end

            // drive selection for each role
            always_comb
            begin
                is_in_v[p]      = 1'b0;
                is_out_v[p]     = 1'b0;
                pad_out_nxt[p]  = 1'b0;
                pad_oe_n_nxt[p] = 1'b1;
                case (eff_mode[p])
                    cpb_pkg::CPB_IN:
                    begin
                        is_in_v[p] = 1'b1;
                    end
                    cpb_pkg::CPB_OUT:
                    begin
                        is_out_v[p]     = 1'b1;
                        pad_out_nxt[p]  = out_value[p];
                        pad_oe_n_nxt[p] = 1'b0;
                    end
                    cpb_pkg::CPB_ALT:
                    begin
                        if (p < cpb_pkg::NUM_PRI && i2c_sel[p % cpb_pkg::NUM_PRI])
                        begin
                            pad_oe_n_nxt[p] = ~i2c_pull_low[p % cpb_pkg::NUM_PRI];
                        end
                        else if (p == cpb_pkg::PAD_NET_STATUS)
                        begin
                            pad_out_nxt[p]  = network_status_indicator;
                            pad_oe_n_nxt[p] = 1'b0;
                        end
                        else if (p == cpb_pkg::PAD_SW_READY)
                        begin
                            pad_out_nxt[p]  = software_ready_indicator;
                            pad_oe_n_nxt[p] = 1'b0;
                        end
                        else
                        begin
                            pad_out_nxt[p]  = alt_out[p];
                            pad_oe_n_nxt[p] = ~alt_oe[p];
                        end
                    end
                    default:
                    begin
                        is_in_v[p] = 1'b1;
                    end
                endcase
            end
        end
    endgenerate

    // registered pad drive
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pad_out  <= cpb_pkg::OUT_RST;
            pad_oe_n <= cpb_pkg::OE_N_RST;
        end
        else
        begin
            pad_out  <= pad_out_nxt;
            pad_oe_n <= pad_oe_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt and wakeup flags
    always_comb
    begin
        set_v          = (pin_sync ^ pin_prev_r) & is_in_v & irq_enable;
        irq_status_nxt = (irq_status & ~irq_clear) | set_v; // set wins over clear
    end

    // sticky status, summary and wake request
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            irq_status <= cpb_pkg::STATUS_RST;
            irq        <= 1'b0;
            wake       <= 1'b0;
        end
        else
        begin
            irq_status <= irq_status_nxt;
            irq        <= |irq_status_nxt;
            wake       <= |(irq_status_nxt & wake_enable & cpb_pkg::WAKE_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_push_pull;
        1 |-> ((pad_oe_n & $past(is_out_v)) == 27'h0);
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("output pad not driven");

    property p_out_level;
        1 |-> ((pad_out & $past(is_out_v)) == ($past(out_value) & $past(is_out_v)));
    endproperty
    a_out_level: assert property (p_out_level) else $error("output pad level wrong");

    property p_in_undriven;
        1 |-> ((~pad_oe_n & $past(is_in_v)) == 27'h0);
    endproperty
    a_in_undriven: assert property (p_in_undriven) else $error("input pad driven");

    property p_latch_hold;
        (out_wr_en == 27'h0) |=> $stable(out_value);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("output latch changed");

    property p_wake_pads;
        1 |-> (wake == |(irq_status & $past(wake_enable) & cpb_pkg::WAKE_MASK));
    endproperty
    a_wake_pads: assert property (p_wake_pads) else $error("wake from wrong pad");

    property p_set_wins;
        (set_v != 27'h0) |=> ((irq_status & $past(set_v)) == $past(set_v));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("input event lost");

    property p_net_default;
        $past(reset) |-> (mode_r[0] == cpb_pkg::CPB_ALT);
    endproperty
    a_net_default: assert property (p_net_default) else $error("pad one not indicator");

    property p_ready_low;
        $past(reset) |-> (!pad_oe_n[7] && !pad_out[7]);
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready pad not low");

    property p_periph_owns;
        (periph_unused == 4'h0) |-> ((is_in_v[26:10] | is_out_v[26:10]) == 17'h0);
    endproperty
    a_periph_owns: assert property (p_periph_owns) else $error("busy pad reassigned");

endmodule

//--- tb/cpb_board.sv
// carrier-board devices that drive the pad bank's pads
`timescale 1ns/1ps
module cpb_board (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // module side of the pads
    input  wire logic [26:0] pad_out,
    input  wire logic [26:0] pad_oe_n,
    // device drive requested by the bench
    input  wire logic [26:0] ext_en,
    input  wire logic [26:0] ext_val,
    // resolved pad level
    output logic      [26:0] pad_in
);
    logic [26:0] float_r;
    logic [26:0] dev_en;

    ////////////////////////////////////////////////////////////////////////////
    // undriven pads wander every cycle so a stale level never looks driven
    always_ff @(posedge clock)
    begin
        if (reset)
            float_r <= 27'h0;
        else
            float_r <= ~float_r;
    end

    // devices stay off during power-up, so boot pads are never pulled high
    assign dev_en = reset ? 27'h0 : ext_en;

    // wire level: module drive first, then a device, then the floating level
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & dev_en & ext_val)
                  | (pad_oe_n & ~dev_en & float_r);
endmodule

//--- tb/testbench.sv
// self-checking bench for the configurable pad bank
`timescale 1ns/1ps
module testbench;
    logic        clock, reset, mode_wr, irq, wake;
    logic        network_status_indicator, software_ready_indicator;
    logic [26:0] pad_in, pad_out, pad_oe_n, out_wr_en, out_wr_data, out_value, in_value;
    logic [26:0] alt_out, alt_oe, irq_enable, irq_clear, wake_enable, irq_status;
    logic [26:0] ext_en, ext_val;
    logic [53:0] mode_wr_data;
    logic [3:0]  periph_unused;
    logic [9:0]  i2c_sel, i2c_pull_low;
    int          error_cnt, checks_done, cycles;

    cpb_pad_bank u_cpb_pad_bank (.clock, .reset, .pad_in, .pad_out, .pad_oe_n, .mode_wr,
        .mode_wr_data, .periph_unused, .out_wr_en, .out_wr_data, .out_value, .in_value,
        .alt_out, .alt_oe, .i2c_sel, .i2c_pull_low, .network_status_indicator,
        .software_ready_indicator, .irq_enable, .irq_clear, .wake_enable, .irq_status,
        .irq, .wake);
    cpb_board u_cpb_board (.clock, .reset, .pad_out, .pad_oe_n, .ext_en, .ext_val, .pad_in);

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access tasks
    task automatic clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input logic [26:0] seen, input logic [26:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic write_modes(input logic [53:0] d);
        mode_wr = 1'b1;
        mode_wr_data = d;
        clk(1);
        mode_wr = 1'b0;
        clk(3);
    endtask
    task automatic write_out(input logic [26:0] en, input logic [26:0] d);
        out_wr_en = en;
        out_wr_data = d;
        clk(1);
        out_wr_en = 27'h0;
        clk(3);
    endtask
    task automatic clear_irq();
        irq_clear = {27{1'b1}};
        clk(1);
        irq_clear = 27'h0;
        clk(1);
    endtask
    task automatic give_verdict();
        $display("checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [53:0] m;
        {reset, mode_wr, network_status_indicator, software_ready_indicator} = 4'h8;
        {out_wr_en, out_wr_data, alt_out, alt_oe, irq_enable, irq_clear} = '0;
        {wake_enable, ext_en, ext_val, mode_wr_data, i2c_sel, i2c_pull_low} = '0;
        periph_unused = 4'h0;
        repeat (16) @(posedge clock);
        #1;
        check(pad_oe_n & 27'h81, 27'h0);
        reset = 1'b0;
        network_status_indicator = 1'b1;
        clk(3);
        check(pad_out & 27'h81, 27'h1);
        software_ready_indicator = 1'b1;
        clk(3);
        check(pad_out & 27'h81, 27'h81);
        // output role, push-pull drive and latch readback
        periph_unused = 4'hf;
        write_modes({27{2'h1}});
        write_out({27{1'b1}}, 27'h2a5a5a5);
        check(out_value, 27'h2a5a5a5);
        check(pad_out, 27'h2a5a5a5);
        check(pad_oe_n, 27'h0);
        check(pad_out & 27'h3ff, 27'h1a5);
        write_out(27'h1, 27'h0);
        check(out_value, 27'h2a5a5a4);
        // uart pads owned by their peripheral stay with internal logic
        periph_unused = 4'hb;
        clk(3);
        check(pad_oe_n & 27'h780000, 27'h780000);
        alt_out = 27'h780000;
        alt_oe = 27'h780000;
        clk(3);
        check(pad_oe_n & 27'h780000, 27'h0);
        check(pad_out & 27'h780000, 27'h780000);
        check(out_value, 27'h2a5a5a4);
        // open-drain bus signal on primary pad six
        m = {27{2'h1}};
        m[11:10] = 2'h2;
        m[13:12] = 2'h3;
        write_modes(m);
        i2c_sel = 10'h20;
        i2c_pull_low = 10'h20;
        clk(3);
        check((pad_oe_n | pad_out) & 27'h20, 27'h0);
        check(pad_oe_n & 27'h40, 27'h40);
        i2c_pull_low = 10'h0;
        clk(3);
        check(pad_oe_n & 27'h20, 27'h20);
        // inputs, interrupts and wakeup on every primary pad
        periph_unused = 4'hf;
        ext_en = 27'h3ff;
        irq_enable = 27'h3ff;
        wake_enable = {27{1'b1}};
        write_modes({27{2'h0}});
        clk(4);
        clear_irq();
        for (int p = 0; p < 10; p++)
        begin
            ext_val[p] = 1'b1;
            clk(5);
            check(in_value & 27'h3ff, 27'h1 << p);
            check(irq_status, 27'h1 << p);
            check({26'h0, irq}, 27'h1);
            check({26'h0, wake}, {26'h0, p == 0 || p == 3 || p == 4 || p == 7});
            clear_irq();
            ext_val[p] = 1'b0;
            clk(5);
            clear_irq();
            check({26'h0, irq}, 27'h0);
        end
        // event and clear in one cycle, wake disabled on pad four
        wake_enable = ~27'h8;
        ext_val[3] = 1'b1;
        clk(2);
        irq_clear = {27{1'b1}};
        clk(1);
        irq_clear = 27'h0;
        check(irq_status, 27'h8);
        check({26'h0, wake}, 27'h0);
        give_verdict();
    end
endmodule
